/* File: logic/febs_pkg.sv */
// package: flash sequencer host constants, register map and carrier types
`default_nettype none
package febs_pkg;
  // command codes
  localparam logic [7:0] cmd_unlock1      = 8'haa;
  localparam logic [7:0] cmd_unlock2      = 8'h55;
  localparam logic [7:0] cmd_bypass_entry = 8'h20;
  localparam logic [7:0] cmd_program      = 8'ha0;
  localparam logic [7:0] cmd_bypass_exit1 = 8'h90;
  localparam logic [7:0] cmd_bypass_exit2 = 8'h00;
  localparam logic [7:0] cmd_erase_setup  = 8'h80;
  localparam logic [7:0] cmd_chip_erase   = 8'h10;
  localparam logic [7:0] cmd_sector_erase = 8'h30;
  localparam logic [7:0] cmd_suspend      = 8'hb0;
  localparam logic [7:0] cmd_resume       = 8'h30;
  localparam logic [7:0] cmd_autoselect   = 8'h90;
  localparam logic [7:0] cmd_reset        = 8'hf0;
  // unlock addresses (word mode)
  localparam logic [19:0] addr_unlock1    = 20'h00555;
  localparam logic [19:0] addr_unlock2    = 20'h002aa;
  // sector identity
  localparam int          sector_lsb      = 12;
  localparam int          sector_bits     = 8;
  // status bit positions on the data lines
  localparam int          poll_bit_pos            = 7;
  localparam int          toggle_bit_pos          = 6;
  localparam int          erase_window_bit_pos    = 3;
  localparam int          suspend_toggle_bit_pos  = 2;
  // flash bus timing, in ns and derived cycles at 50 MHz
  localparam int          clk_period_ns   = 20;
  localparam int          t_setup_ns      = 40;
  localparam int          t_pulse_ns      = 60;
  localparam int          t_hold_ns       = 40;
  localparam int          t_read_ns       = 100;
  localparam int          window_ns       = 50000;
  localparam logic [7:0]  setup_cyc = 8'((t_setup_ns + clk_period_ns - 1) / clk_period_ns);
  localparam logic [7:0]  pulse_cyc = 8'((t_pulse_ns + clk_period_ns - 1) / clk_period_ns);
  localparam logic [7:0]  hold_cyc  = 8'((t_hold_ns + clk_period_ns - 1) / clk_period_ns);
  localparam logic [7:0]  read_cyc  = 8'((t_read_ns + clk_period_ns - 1) / clk_period_ns);
  // length of the window for queued sector writes, in cycles
  localparam logic [15:0] window_cyc = 16'(window_ns / clk_period_ns);
  // apb register offsets
  localparam logic [11:0] reg_ctrl   = 12'h000;
  localparam logic [11:0] reg_addr   = 12'h004;
  localparam logic [11:0] reg_data   = 12'h008;
  localparam logic [11:0] reg_status = 12'h00c;
  localparam logic [11:0] reg_rdata  = 12'h010;
  // ctrl fields: op in [3:0], written value launches it
  localparam int          ctrl_op_lsb = 0;
  localparam logic [31:0] ctrl_reset  = 32'h0000_0000;
  // status bits
  localparam int          st_busy_pos   = 0;
  localparam int          st_bypass_pos = 1;
  localparam int          st_rb_pos     = 2;
  localparam int          st_err_pos    = 3;

  typedef enum logic [3:0] {
    febs_op_none,
    febs_op_bypass_enter,
    febs_op_bypass_prog,
    febs_op_bypass_exit,
    febs_op_chip_erase,
    febs_op_sector_erase,
    febs_op_sector_add,
    febs_op_suspend,
    febs_op_resume,
    febs_op_read,
    febs_op_reset,
    febs_op_autoselect
  } febs_op_t;

  // one flash bus cycle as handed to the pin engine
  typedef struct packed {
    logic        write;
    logic [19:0] addr;
    logic [7:0]  data;
  } febs_cyc_t;

  // flash pins driven by the host
  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        reset_n;
    logic [19:0] addr;
  } febs_pins_t;
endpackage : febs_pkg
`default_nettype wire

/* File: logic/febs_bus_cycle.sv */
// flash pin engine: one timed write or read cycle on the asynchronous bus
`default_nettype none
module febs_bus_cycle (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 start,
  input  wire febs_pkg::febs_cyc_t  cyc,
  output logic                      done,
  output logic [7:0]                rdata,
  output febs_pkg::febs_pins_t      pins,
  output logic [7:0]                dq_out,
  output logic                      dq_oe_n,
  input  wire logic [7:0]           dq_in_sync
);
  typedef enum {s_idle, s_setup, s_pulse, s_hold} febs_bc_state_t;
  febs_bc_state_t state;
  logic [7:0]     cnt;
  logic           is_write;

  wire cnt_zero = (cnt == 8'h00);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      state    <= s_idle;
      cnt      <= 8'h00;
      is_write <= 1'b0;
      done     <= 1'b0;
      rdata    <= 8'h00;
      pins     <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b0, addr: 20'h00000};
      dq_out   <= 8'h00;
      dq_oe_n  <= 1'b1;
    end
    else
    begin
      done         <= 1'b0;
      pins.reset_n <= 1'b1;
      unique case (state)
        s_idle:
          if (start)
          begin
            // address settles with ce low before the strobe falls
            is_write  <= cyc.write;
            pins.addr <= cyc.addr;
            pins.ce_n <= 1'b0;
            dq_out    <= cyc.data;
            dq_oe_n   <= !cyc.write;
            cnt       <= febs_pkg::setup_cyc;
            state     <= s_setup;
          end
        s_setup:
          if (cnt_zero)
          begin
            pins.we_n <= !is_write;
            pins.oe_n <= is_write;
            cnt       <= is_write ? febs_pkg::pulse_cyc : febs_pkg::read_cyc;
            state     <= s_pulse;
          end
          else
            cnt <= cnt - 8'h01;
        s_pulse:
          if (cnt_zero)
          begin
            // data is held past the rising strobe, where the device latches it
            rdata     <= dq_in_sync;
            pins.we_n <= 1'b1;
            pins.oe_n <= 1'b1;
            cnt       <= febs_pkg::hold_cyc;
            state     <= s_hold;
          end
          else
            cnt <= cnt - 8'h01;
        s_hold:
          if (cnt_zero)
          begin
            pins.ce_n <= 1'b1;
            dq_oe_n   <= 1'b1;
            done      <= 1'b1;
            state     <= s_idle;
          end
          else
            cnt <= cnt - 8'h01;
      endcase
    end
endmodule : febs_bus_cycle
`default_nettype wire

/* File: logic/febs_host.sv */
// flash erase/bypass host controller: apb registers, command sequences, status polling
// Operation
// - bypass entry: two unlock writes then code 20h
// - bypass program: code a0h then address and data, repeatable
// - bypass exit: 90h then 00h at any address
// - chip erase: six writes ending with full-erase code
// - hardware reset aborts erase; host must reissue sequence
// - sector erase: six writes, last carries sector address and 30h
// - extra sector writes spaced under the window length
// - other commands in the window cancel; host rewrites all
// - resume at any address; repeats ignored; suspend again allowed
`default_nettype none
module febs_host (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  output febs_pkg::febs_pins_t      flash_pins,
  output logic [7:0]                data_lines_out,
  output logic                      data_lines_oe_n,
  input  wire logic [7:0]           data_lines_in,
  input  wire logic                 ready_busy_n
);
  typedef enum {h_idle, h_issue, h_wait, h_poll, h_poll_wait, h_hwreset} febs_h_state_t;

  febs_h_state_t        state;
  febs_pkg::febs_op_t   op;
  logic [19:0]          op_addr;
  logic [7:0]           op_data;
  logic [2:0]           step;
  logic                 bypass;
  logic                 suspended;
  logic                 chip_busy;
  logic                 err;
  logic [7:0]           last_read;
  logic [7:0]           prev_poll;
  logic [7:0]           rst_cnt;
  logic                 busy;
  logic [7:0]           dq_s1, dq_s2;
  logic                 rb_s1, rb_s2;
  logic                 bc_start;
  febs_pkg::febs_cyc_t  bc_cyc;
  logic                 bc_done;
  logic [7:0]           bc_rdata;

  // pin inputs pass two flops
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      dq_s1 <= 8'h00;
      dq_s2 <= 8'h00;
      rb_s1 <= 1'b1;
      rb_s2 <= 1'b1;
    end
    else
    begin
      dq_s1 <= data_lines_in;
      dq_s2 <= dq_s1;
      rb_s1 <= ready_busy_n;
      rb_s2 <= rb_s1;
    end

  function automatic logic [2:0] seq_len(input febs_pkg::febs_op_t o);
    unique case (o)
      febs_pkg::febs_op_bypass_enter: seq_len = 3'd3;
      febs_pkg::febs_op_bypass_prog:  seq_len = 3'd2;
      febs_pkg::febs_op_bypass_exit:  seq_len = 3'd2;
      febs_pkg::febs_op_chip_erase:   seq_len = 3'd6;
      febs_pkg::febs_op_sector_erase: seq_len = 3'd6;
      febs_pkg::febs_op_autoselect:   seq_len = 3'd3;
      default:                        seq_len = 3'd1;
    endcase
  endfunction : seq_len

  // one bus cycle of a sequence, picked by op and step
  function automatic febs_pkg::febs_cyc_t seq_cyc(input febs_pkg::febs_op_t o,
    input logic [2:0] s, input logic [19:0] a, input logic [7:0] d);
    febs_pkg::febs_cyc_t c;
    logic [19:0] sect;
    c    = '{write: 1'b1, addr: 20'h00000, data: 8'h00};
    sect = {a[febs_pkg::sector_lsb +: febs_pkg::sector_bits], 12'h000};
    unique case (o)
      febs_pkg::febs_op_bypass_enter, febs_pkg::febs_op_autoselect:
        unique case (s)
          3'd0: c = '{1'b1, febs_pkg::addr_unlock1, febs_pkg::cmd_unlock1};
          3'd1: c = '{1'b1, febs_pkg::addr_unlock2, febs_pkg::cmd_unlock2};
          default: c = '{1'b1, febs_pkg::addr_unlock1,
            (o == febs_pkg::febs_op_autoselect) ? febs_pkg::cmd_autoselect
                                                : febs_pkg::cmd_bypass_entry};
        endcase
      febs_pkg::febs_op_bypass_prog:
        if (s == 3'd0)
          c = '{1'b1, 20'h00000, febs_pkg::cmd_program};
        else
          c = '{1'b1, a, d};
      febs_pkg::febs_op_bypass_exit:
        c = '{1'b1, 20'h00000,
              (s == 3'd0) ? febs_pkg::cmd_bypass_exit1 : febs_pkg::cmd_bypass_exit2};
      febs_pkg::febs_op_chip_erase, febs_pkg::febs_op_sector_erase:
        unique case (s)
          3'd0, 3'd3: c = '{1'b1, febs_pkg::addr_unlock1, febs_pkg::cmd_unlock1};
          3'd1, 3'd4: c = '{1'b1, febs_pkg::addr_unlock2, febs_pkg::cmd_unlock2};
          3'd2:       c = '{1'b1, febs_pkg::addr_unlock1, febs_pkg::cmd_erase_setup};
          default:
            if (o == febs_pkg::febs_op_chip_erase)
              c = '{1'b1, febs_pkg::addr_unlock1, febs_pkg::cmd_chip_erase};
            else
              c = '{1'b1, sect, febs_pkg::cmd_sector_erase};
        endcase
      febs_pkg::febs_op_sector_add: c = '{1'b1, sect, febs_pkg::cmd_sector_erase};
      febs_pkg::febs_op_suspend:    c = '{1'b1, 20'h00000, febs_pkg::cmd_suspend};
      febs_pkg::febs_op_resume:     c = '{1'b1, 20'h00000, febs_pkg::cmd_resume};
      febs_pkg::febs_op_reset:      c = '{1'b1, 20'h00000, febs_pkg::cmd_reset};
      febs_pkg::febs_op_read:       c = '{1'b0, a, 8'h00};
      default:                      c = '{1'b0, a, 8'h00};
    endcase
    seq_cyc = c;
  endfunction : seq_cyc

  // apb decode
  wire        apb_access = psel && penable;
  wire        apb_wr     = apb_access && pwrite;
  wire        known      = (paddr == febs_pkg::reg_ctrl) || (paddr == febs_pkg::reg_addr) ||
                           (paddr == febs_pkg::reg_data) || (paddr == febs_pkg::reg_status) ||
                           (paddr == febs_pkg::reg_rdata);
  wire febs_pkg::febs_op_t new_op =
    febs_pkg::febs_op_t'(pwdata[febs_pkg::ctrl_op_lsb +: 4]);
  wire        launch     = apb_wr && (paddr == febs_pkg::reg_ctrl) && !busy;
  // only the legal command for the device's current mode is sent
  wire        op_legal   =
    bypass    ? (new_op == febs_pkg::febs_op_bypass_prog ||
                 new_op == febs_pkg::febs_op_bypass_exit) :
    chip_busy ? 1'b0 :
    suspended ? (new_op != febs_pkg::febs_op_suspend &&
                 new_op != febs_pkg::febs_op_chip_erase &&
                 new_op != febs_pkg::febs_op_sector_erase) :
                (new_op != febs_pkg::febs_op_none && new_op != febs_pkg::febs_op_resume);
  // codes past the last defined op are refused, never sent as a bare read
  wire        op_ok      = op_legal && (new_op <= febs_pkg::febs_op_autoselect);
  wire [31:0] status_word = {28'h0000000, err, rb_s2, bypass, busy};
  wire [31:0] rd_mux =
    (paddr == febs_pkg::reg_addr)   ? {12'h000, op_addr} :
    (paddr == febs_pkg::reg_data)   ? {24'h000000, op_data} :
    (paddr == febs_pkg::reg_status) ? {status_word[31:5], suspended, status_word[3:0]} :
    (paddr == febs_pkg::reg_rdata)  ? {24'h000000, last_read} :
    (paddr == febs_pkg::reg_ctrl)   ? {28'h0000000, 4'(op)} : 32'h00000000;
  // toggle bit stops toggling when the embedded routine is done
  wire        toggling   = (prev_poll[febs_pkg::toggle_bit_pos] !=
                            bc_rdata[febs_pkg::toggle_bit_pos]);
  wire        done_pol   = !toggling && rb_s2;

  assign busy     = (state != h_idle);
  assign bc_start = (state == h_issue);
  assign bc_cyc   = (state == h_poll) ? febs_pkg::febs_cyc_t'{1'b0, op_addr, 8'h00}
                                      : seq_cyc(op, step, op_addr, op_data);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
      op_addr <= 20'h00000;
      op_data <= 8'h00;
    end
    else
    begin
      pready  <= psel && !pready;
      prdata  <= rd_mux;
      // error only rides on the ready pulse, never on the cycle after it
      pslverr <= psel && !pready && !known;
      if (apb_wr && paddr == febs_pkg::reg_addr)
        op_addr <= pwdata[19:0];
      if (apb_wr && paddr == febs_pkg::reg_data)
        op_data <= pwdata[7:0];
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      state     <= h_idle;
      op        <= febs_pkg::febs_op_none;
      step      <= 3'd0;
      bypass    <= 1'b0;
      suspended <= 1'b0;
      chip_busy <= 1'b0;
      err       <= 1'b0;
      last_read <= 8'h00;
      prev_poll <= 8'h00;
      rst_cnt   <= 8'h00;
    end
    else
      unique case (state)
        h_idle:
          if (launch && pready)
          begin
            err <= !op_ok;
            if (op_ok)
            begin
              op    <= new_op;
              step  <= 3'd0;
              state <= (new_op == febs_pkg::febs_op_reset) ? h_hwreset : h_issue;
              rst_cnt <= febs_pkg::pulse_cyc;
            end
          end
        h_issue:
          state <= h_wait;
        h_wait:
          if (bc_done)
          begin
            if (step != seq_len(op) - 3'd1)
            begin
              step  <= step + 3'd1;
              state <= h_issue;
            end
            else
            begin
              last_read <= bc_rdata;
              prev_poll <= bc_rdata;
              unique case (op)
                febs_pkg::febs_op_bypass_enter: bypass <= 1'b1;
                febs_pkg::febs_op_bypass_exit:  bypass <= 1'b0;
                febs_pkg::febs_op_resume:       suspended <= 1'b0;
                febs_pkg::febs_op_chip_erase:   chip_busy <= 1'b1;
                default: ;
              endcase
              // wait for the embedded routine or the suspend to settle
              state <= (op == febs_pkg::febs_op_bypass_prog ||
                        op == febs_pkg::febs_op_chip_erase ||
                        op == febs_pkg::febs_op_suspend) ? h_poll : h_idle;
            end
          end
        h_poll:
          state <= h_poll_wait;
        h_poll_wait:
          if (bc_done)
          begin
            prev_poll <= bc_rdata;
            last_read <= bc_rdata;
            if (done_pol)
            begin
              chip_busy <= 1'b0;
              if (op == febs_pkg::febs_op_suspend)
                suspended <= 1'b1;
              state <= h_idle;
            end
            else
              state <= h_poll;
          end
        h_hwreset:
        begin
          // reset pulse aborts any erase; all modes clear
          bypass    <= 1'b0;
          suspended <= 1'b0;
          chip_busy <= 1'b0;
          if (rst_cnt == 8'h00)
            state <= h_idle;
          else
            rst_cnt <= rst_cnt - 8'h01;
        end
      endcase

  febs_pkg::febs_pins_t bc_pins;
  febs_bus_cycle u_cycle (
    .pclk       (pclk),
    .presetn    (presetn),
    .start      (bc_start || state == h_poll),
    .cyc        (bc_cyc),
    .done       (bc_done),
    .rdata      (bc_rdata),
    .pins       (bc_pins),
    .dq_out     (data_lines_out),
    .dq_oe_n    (data_lines_oe_n),
    .dq_in_sync (dq_s2)
  );

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      flash_pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b0, addr: 20'h00000};
    else
    begin
      flash_pins         <= bc_pins;
      flash_pins.reset_n <= !(state == h_hwreset);
    end
endmodule : febs_host
`default_nettype wire

/* File: testbench/febs_host_assertions.sv */
// checker: apb handshake and flash pin timing of the host controller
`default_nettype none
module febs_host_assertions (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire febs_pkg::febs_pins_t flash_pins,
  input wire logic [7:0]           data_lines_out,
  input wire logic                 data_lines_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_RDY_PULSE: assert property (pready |=> !pready) else $error("pready held");
  AST_RDY_SETUP: assert property (psel && !penable |=> pready) else $error("pready late");
  AST_ERR_RDY: assert property (pslverr |-> pready) else $error("pslverr alone");
  AST_WE_CE: assert property (!flash_pins.we_n |-> !flash_pins.ce_n && flash_pins.oe_n)
    else $error("write strobe without select");
  AST_WE_PULSE: assert property ($fell(flash_pins.we_n) |->
    !flash_pins.we_n [*4] ##1 flash_pins.we_n) else $error("write pulse width");
  AST_CE_SETUP: assert property ($fell(flash_pins.we_n) |->
    $past(flash_pins.ce_n, 2) == 1'b0) else $error("select setup");
  AST_ADDR_HOLD: assert property (!flash_pins.we_n |=> $stable(flash_pins.addr))
    else $error("address moved");
  AST_DATA_HOLD: assert property (!flash_pins.we_n |-> !data_lines_oe_n
    ##1 $stable(data_lines_out)) else $error("data moved");
  AST_NO_FIGHT: assert property (!data_lines_oe_n |-> flash_pins.oe_n)
    else $error("bus contention");
  AST_RESET_QUIET: assert property (!flash_pins.reset_n |-> flash_pins.we_n)
    else $error("write during reset");
endmodule : febs_host_assertions
bind febs_host febs_host_assertions u_febs_host_assertions (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .flash_pins(flash_pins), .data_lines_out(data_lines_out), .data_lines_oe_n(data_lines_oe_n));
`default_nettype wire

/* File: testbench/febs_flash_model.sv */
// behavioural flash device: command decoder, erase timers, status reads
`default_nettype none
module febs_flash_model #(
  parameter int erase_us = 30,
  parameter int prog_us  = 2
) (
  input  wire febs_pkg::febs_pins_t flash_pins,
  input  wire logic [7:0]           host_dq,
  input  wire logic                 host_oe_n,
  output logic [7:0]                dq,
  output logic                      ready_busy_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]   mem [1048576];
  logic [255:0] sel;
  logic [19:0]  la;
  logic [7:0]   pd;
  int           seq, win_t, er_t, chip_t, prog_t, sus_t;
  logic         bypass, suspended, tog, stog;
  wire  [7:0]   sec  = flash_pins.addr[19:12];
  wire          busy = prog_t > 0 || chip_t > 0 || win_t > 0 || er_t > 0 && !suspended;
  wire          st_rd = busy || suspended && sel[sec];
  wire  [7:0]   stat = {suspended ? 1'b1 : prog_t > 0 ? ~pd[7] : 1'b0, tog, 2'b00,
                        er_t > 0 || chip_t > 0, stog, 2'b00};
  assign ready_busy_n = !busy;
  initial
  begin
    {dq, sel, bypass, suspended, tog, stog, pd} = '0;
    foreach (mem[k]) mem[k] = 8'hff;
  end
  always @(negedge flash_pins.reset_n)
  begin
    {seq, win_t, er_t, chip_t, prog_t, sus_t} = '0;
    {bypass, suspended, sel} = '0;
  end
  always @(negedge flash_pins.we_n or negedge flash_pins.ce_n)
    if (!flash_pins.we_n && !flash_pins.ce_n) la = flash_pins.addr;
  always @(posedge flash_pins.we_n or posedge flash_pins.ce_n)
    if (flash_pins.reset_n && (flash_pins.we_n ^ flash_pins.ce_n)) cmd(la, host_dq);
  task automatic cmd(input logic [19:0] a, input logic [7:0] d);
    if (prog_t > 0 || chip_t > 0) return;
    if (win_t > 0)
    begin
      if (d == 8'h30) sel[a[19:12]] = 1'b1;
      else if (d == 8'hb0) {er_t, suspended} = {erase_us, 1'b1};
      else sel = '0;
      win_t = d == 8'h30 ? 50 : 0;
      return;
    end
    if (er_t > 0 && !suspended)
    begin
      if (d == 8'hb0 && sus_t == 0) sus_t = 20;
      return;
    end
    case (seq)
      0: if (bypass) seq = d == 8'ha0 ? 6 : d == 8'h90 ? 7 : 0;
         else if (suspended && d == 8'h30) suspended = 1'b0;
         else seq = a[10:0] == 11'h555 && d == 8'haa ? 1 : 0;
      1: seq = a[10:0] == 11'h2aa && d == 8'h55 ? 2 : 0;
      2:
      begin
        bypass = a[10:0] == 11'h555 && d == 8'h20 && !suspended;
        seq = a[10:0] != 11'h555 ? 0 : d == 8'ha0 ? 6 : d == 8'h80 ? 3 : 0;
      end
      3: seq = d == 8'haa ? 4 : 0;
      4: seq = d == 8'h55 ? 5 : 0;
      5:
      begin
        if (d == 8'h10 && !suspended) chip_t = erase_us;
        if (d == 8'h30 && !suspended) {sel[a[19:12]], win_t} = {1'b1, 32'sd50};
        seq = 0;
      end
      6:
      begin
        mem[a] = d;
        pd = d;
        prog_t = prog_us;
        seq = 0;
      end
      default:
      begin
        bypass = d != 8'h00;
        seq = 0;
      end
    endcase
  endtask : cmd
  // one microsecond device time base
  always #1000
  begin
    if (er_t == 1 && !suspended || chip_t == 1)
      foreach (mem[k]) if (chip_t == 1 || sel[k[19:12]]) mem[k] = 8'hff;
    if (er_t == 1 && !suspended) sel = '0;
    if (win_t == 1) er_t = erase_us;
    if (win_t > 0) win_t--;
    if (sus_t == 1) suspended = 1'b1;
    if (sus_t > 0) sus_t--;
    if (er_t > 0 && !suspended) er_t--;
    if (chip_t > 0) chip_t--;
    if (prog_t > 0) prog_t--;
  end
  always #5
    if (!host_oe_n) dq = host_dq;
    else if (!flash_pins.ce_n && !flash_pins.oe_n) dq = st_rd ? stat : mem[flash_pins.addr];
    else dq = ~dq; // released bus never keeps a stale value
  always @(posedge flash_pins.oe_n)
  begin
    tog ^= busy;
    stog ^= (er_t > 0 || win_t > 0) && sel[sec];
  end
endmodule : febs_flash_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// testbench: apb-driven command scenarios against the flash model
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic                 data_lines_oe_n, ready_busy_n;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata, v;
  logic [7:0]           data_lines_out, data_lines_in;
  febs_pkg::febs_pins_t flash_pins;
  int                   miscompares, checked, cycles;
  febs_host u_febs_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .flash_pins(flash_pins), .data_lines_out(data_lines_out),
    .data_lines_oe_n(data_lines_oe_n), .data_lines_in(data_lines_in),
    .ready_busy_n(ready_busy_n));
  febs_flash_model u_febs_flash_model (.flash_pins(flash_pins), .host_dq(data_lines_out),
    .host_oe_n(data_lines_oe_n), .dq(data_lines_in), .ready_busy_n(ready_busy_n));
  task automatic stop_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    v = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic run_op(input logic [3:0] op, input logic [19:0] a, input logic [7:0] d);
    apb(1'b1, febs_pkg::reg_addr, {12'h000, a});
    apb(1'b1, febs_pkg::reg_data, {24'h000000, d});
    apb(1'b1, febs_pkg::reg_ctrl, {28'h0000000, op});
    do apb(1'b0, febs_pkg::reg_status, 32'h00000000); while (v[0] === 1'b1);
  endtask : run_op
  task automatic read_flash(input logic [19:0] a);
    run_op(4'h9, a, 8'h00);
    apb(1'b0, febs_pkg::reg_rdata, 32'h00000000);
  endtask : read_flash
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // the whole run needs well under ten thousand cycles
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      miscompares++;
      stop_test();
    end
  end
  initial
  begin
    {presetn, psel, penable, pwrite} = '0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, febs_pkg::reg_status, 32'h00000000);
    check(v, 32'h00000004, "idle status");
    apb(1'b0, 12'h0f0, 32'h00000000);
    check({31'h0, e}, 32'h00000001, "unmapped");
    $display("test reset done");
    run_op(4'h1, 20'h00000, 8'h00);
    check(v & 32'h2, 32'h2, "bypass on");
    run_op(4'h2, 20'h12345, 8'h5a);
    run_op(4'h2, 20'h12346, 8'ha5);
    check({24'h0, u_febs_flash_model.mem[20'h12346]}, 32'ha5, "program");
    run_op(4'h3, 20'h00000, 8'h00);
    check(v & 32'h2, 32'h0, "bypass off");
    read_flash(20'h12345);
    check(v, 32'h5a, "array read");
    $display("test bypass done");
    run_op(4'h5, 20'h23000, 8'h00);
    run_op(4'h6, 20'h05000, 8'h00);
    run_op(4'h7, 20'h00000, 8'h00);
    check(v & 32'h10, 32'h10, "suspended");
    read_flash(20'h23abc);
    check(v & 32'h80, 32'h80, "suspended poll");
    read_flash(20'h12345);
    check(v, 32'h5a, "other sector");
    run_op(4'h8, 20'h00000, 8'h00);
    read_flash(20'h05fff);
    check(v & 32'h88, 32'h08, "active erase");
    do apb(1'b0, febs_pkg::reg_status, 32'h00000000); while (v[2] !== 1'b1);
    read_flash(20'h23abc);
    check(v, 32'hff, "erased");
    read_flash(20'h12345);
    check(v, 32'h5a, "kept");
    $display("test sector erase done");
    run_op(4'h4, 20'h00000, 8'h00);
    read_flash(20'h12345);
    check(v, 32'hff, "chip erased");
    apb(1'b1, febs_pkg::reg_ctrl, 32'h0000000c);
    apb(1'b0, febs_pkg::reg_status, 32'h00000000);
    check(v & 32'h8, 32'h8, "illegal op");
    run_op(4'h5, 20'h40000, 8'h00);
    run_op(4'ha, 20'h00000, 8'h00);
    apb(1'b0, febs_pkg::reg_status, 32'h00000000);
    check(v & 32'h5, 32'h4, "aborted");
    $display("test chip erase and abort done");
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
